// ---- hdl/led_fault_pkg.sv ----
/*
  Shared constants, types and helpers of the LED fault detect and
  output stagger block.
  Assumes a single 250 MHz system clock domain for all users.
*/
package led_fault_pkg;

  localparam int CHANNELS    = 16;
  localparam int GROUPS      = 4;
  localparam int SHIFT_LEN   = 192;
  localparam int STATUS_BITS = 17;
  localparam int SYNC_STAGES = 2;

  // shift clock rise that samples the outputs, counted from one
  localparam logic [5:0] SAMPLE_EDGE = 6'h21;
  localparam logic [5:0] COUNT_RST   = 6'h00;

  // register map, byte addresses
  localparam logic [3:0] ADDR_EVENT = 4'h0;
  localparam logic [3:0] ADDR_MASK  = 4'h4;
  localparam logic [3:0] ADDR_OPEN  = 4'h8;
  localparam logic [3:0] ADDR_CTRL  = 4'hC;

  // event bits and the control register bit
  localparam int EVENT_W  = 3;
  localparam int EV_OPEN  = 0;
  localparam int EV_HOT   = 1;
  localparam int EV_COOL  = 2;
  localparam int CTRL_STAGGER = 0;

  localparam logic [EVENT_W-1:0]  EVENT_RST = 3'h0;
  localparam logic [EVENT_W-1:0]  MASK_RST  = 3'h0;
  localparam logic                STAGGER_RST = 1'b1;
  localparam logic [CHANNELS-1:0] CHAN_RST  = 16'h0000;
  localparam logic [31:0]         WORD_ZERO = 32'h0000_0000;

  // pin inputs that arrive from outside the clock domain
  typedef struct packed {
    logic gclk;
    logic sdata;
    logic blank;
    logic latch_n;
    logic hot;
    logic cool;
  } pins_t;

  // word loaded into the top of the shift register
  typedef struct packed {
    logic                overheat;
    logic [CHANNELS-1:0] open_led;
  } status_word_t;

  function automatic logic rose(input logic now, input logic was);
    rose = now & ~was;
  endfunction

  function automatic logic fell(input logic now, input logic was);
    fell = ~now & was;
  endfunction

endpackage

// ---- hdl/led_fault_stagger.sv ----
/*
  Open-LED detection, thermal shutdown and staggered sink switching
  of a 16-channel constant-current LED driver, with a small register
  port and one interrupt.
  Assumes the shift clock, blank, latch strobe, thermal levels,
  comparators and PWM demand arrive from outside the clock domain.
*/
// Our own choices: the register addresses and the address-and-strobe port.
`timescale 1ns/1ns
module led_fault_stagger (
  // clock and control
  input  wire logic        REF_CLK,
  input  wire logic        RST,
  input  wire logic        CE,
  // grayscale serial port from the controller
  input  wire logic        GRAY_SHIFT_CLOCK,
  input  wire logic        GRAY_SERIAL_IN,
  input  wire logic        BLANK,
  input  wire logic        GRAY_LATCH_STROBE_N,
  output logic             GRAY_SERIAL_OUT,
  // analog sense and pwm demand
  input  wire logic        TEMP_HIGH,
  input  wire logic        TEMP_COOL,
  input  wire logic [15:0] OPEN_CMP,
  input  wire logic [15:0] CHANNEL_ON,
  // register port
  input  wire logic [3:0]  REG_ADDR,
  input  wire logic [31:0] REG_WDATA,
  input  wire logic        REG_WR,
  input  wire logic        REG_RD,
  output logic      [31:0] REG_RDATA,
  // outputs
  output logic      [15:0] SINK_OUTPUT,
  output logic             OVERHEAT_FLAG,
  output logic             IRQ
);

  localparam int N = led_fault_pkg::CHANNELS;

  led_fault_pkg::pins_t pins_raw;
  led_fault_pkg::pins_t pins_s;
  led_fault_pkg::pins_t pins_d;
  logic [N-1:0]         cmp_s;
  logic [N-1:0]         demand_s;

  assign pins_raw = '{gclk: GRAY_SHIFT_CLOCK, sdata: GRAY_SERIAL_IN,
                      blank: BLANK, latch_n: GRAY_LATCH_STROBE_N,
                      hot: TEMP_HIGH, cool: TEMP_COOL};

  led_pin_sync #(.W($bits(led_fault_pkg::pins_t))) u_pin_sync (
    .clk (REF_CLK),
    .ce  (CE),
    .rst (RST),
    .d   (pins_raw),
    .q   (pins_s)
  );

  led_pin_sync #(.W(2*N)) u_sense_sync (
    .clk (REF_CLK),
    .ce  (CE),
    .rst (RST),
    .d   ({OPEN_CMP, CHANNEL_ON}),
    .q   ({cmp_s, demand_s})
  );

  // edge detection on synchronised levels only
  led_fault_pkg::pins_t pins_d_next;
  logic g_rise;
  logic blank_fall;
  logic latch_fall;

  always_comb begin
    pins_d_next = pins_d;
    if (RST) begin
      pins_d_next = '0;
    end else if (CE) begin
      pins_d_next = pins_s;
    end
  end

  always_ff @(posedge REF_CLK) begin
    pins_d <= pins_d_next;
  end

  assign g_rise     = CE & led_fault_pkg::rose(pins_s.gclk, pins_d.gclk);
  assign blank_fall = CE & led_fault_pkg::fell(pins_s.blank, pins_d.blank);
  assign latch_fall = CE & led_fault_pkg::fell(pins_s.latch_n,
                                               pins_d.latch_n);

  // open-LED sampling
  logic [5:0]   gcount_reg;
  logic [5:0]   gcount_next;
  logic         counting_reg;
  logic         counting_next;
  logic [N-1:0] open_reg;
  logic [N-1:0] open_next;
  logic [N-1:0] open_cap;
  logic         sample;

  // an off channel cannot be judged, so it reads as healthy
  assign open_cap = cmp_s & SINK_OUTPUT;
  assign sample   = g_rise && counting_reg &&
                    (gcount_reg + 6'h01 == led_fault_pkg::SAMPLE_EDGE);

  always_comb begin
    gcount_next   = gcount_reg;
    counting_next = counting_reg;
    open_next     = open_reg;
    if (RST) begin
      gcount_next   = led_fault_pkg::COUNT_RST;
      counting_next = 1'b0;
      open_next     = led_fault_pkg::CHAN_RST;
    end else if (blank_fall) begin
      // every PWM cycle rearms the check by itself
      gcount_next   = led_fault_pkg::COUNT_RST;
      counting_next = 1'b1;
    end else if (sample) begin
      open_next     = open_cap;
      counting_next = 1'b0;
    end else if (g_rise && counting_reg) begin
      gcount_next   = gcount_reg + 6'h01;
    end
  end

  always_ff @(posedge REF_CLK) begin
    gcount_reg   <= gcount_next;
    counting_reg <= counting_next;
    open_reg     <= open_next;
  end

  // thermal flag and restart
  logic flag_next;
  logic run_reg;
  logic run_next;
  logic resume_reg;
  logic resume_next;

  always_comb begin
    flag_next   = OVERHEAT_FLAG;
    run_next    = run_reg;
    resume_next = resume_reg;
    if (RST) begin
      flag_next   = 1'b0;
      run_next    = 1'b0;
      resume_next = 1'b0;
    end else if (CE) begin
      // set wins over the cool indication
      if (pins_s.hot) begin
        flag_next = 1'b1;
      end else if (pins_s.cool) begin
        flag_next = 1'b0;
      end
      if (blank_fall) begin
        resume_next = 1'b1;
      end
      if (OVERHEAT_FLAG) begin
        run_next = 1'b0;
      end else if (g_rise && resume_reg) begin
        run_next    = 1'b1;
        resume_next = 1'b0;
      end
    end
  end

  always_ff @(posedge REF_CLK) begin
    OVERHEAT_FLAG <= flag_next;
    run_reg       <= run_next;
    resume_reg    <= resume_next;
  end

  // grouped output switching
  logic [N-1:0] stage_reg [3];
  logic [N-1:0] stage_next [3];
  logic [N-1:0] staggered;
  logic [N-1:0] sink_next;
  logic         permit;
  logic         stagger_en_reg;

  // forced off is immediate; only pwm edges are staggered
  assign permit = run_reg & ~OVERHEAT_FLAG & ~pins_s.blank;

  always_comb begin
    for (int k = 0; k < 3; k++) begin
      stage_next[k] = stage_reg[k];
    end
    if (RST) begin
      for (int k = 0; k < 3; k++) begin
        stage_next[k] = led_fault_pkg::CHAN_RST;
      end
    end else if (g_rise) begin
      stage_next[0] = demand_s;
      stage_next[1] = stage_reg[0];
      stage_next[2] = stage_reg[1];
    end
    for (int i = 0; i < N; i++) begin
      // group n mod 4 waits that many shift clock periods
      if (i % led_fault_pkg::GROUPS == 0) begin
        staggered[i] = demand_s[i];
      end else begin
        staggered[i] = stage_reg[i % led_fault_pkg::GROUPS - 1][i];
      end
    end
    sink_next = SINK_OUTPUT;
    if (RST) begin
      sink_next = led_fault_pkg::CHAN_RST;
    end else if (CE) begin
      sink_next = permit ? (stagger_en_reg ? staggered : demand_s)
                         : led_fault_pkg::CHAN_RST;
    end
  end

  always_ff @(posedge REF_CLK) begin
    for (int k = 0; k < 3; k++) begin
      stage_reg[k] <= stage_next[k];
    end
    SINK_OUTPUT <= sink_next;
  end

  // status load into the shift register
  logic                       load_pend_reg;
  logic                       load_pend_next;
  logic                       load_now;
  led_fault_pkg::status_word_t status;

  assign load_now = g_rise & load_pend_reg;
  assign status   = '{overheat: OVERHEAT_FLAG, open_led: open_reg};

  always_comb begin
    load_pend_next = load_pend_reg;
    if (RST) begin
      load_pend_next = 1'b0;
    end else if (latch_fall) begin
      load_pend_next = 1'b1;
    end else if (g_rise) begin
      load_pend_next = 1'b0;
    end
  end

  always_ff @(posedge REF_CLK) begin
    load_pend_reg <= load_pend_next;
  end

  led_gray_shift u_shift (
    .clk        (REF_CLK),
    .ce         (CE),
    .rst        (RST),
    .shift_en   (g_rise & ~load_pend_reg),
    .load_en    (load_now),
    .serial_in  (pins_s.sdata),
    .status     (status),
    .serial_out (GRAY_SERIAL_OUT)
  );

  // registers and interrupt
  logic [2:0]  event_reg;
  logic [2:0]  event_next;
  logic [2:0]  event_set;
  logic [2:0]  mask_reg;
  logic [2:0]  mask_next;
  logic        stagger_en_next;
  logic [31:0] rdata_next;
  logic        irq_next;

  always_comb begin
    event_set = '0;
    event_set[led_fault_pkg::EV_OPEN] = sample && (|open_cap);
    event_set[led_fault_pkg::EV_HOT]  = flag_next & ~OVERHEAT_FLAG;
    event_set[led_fault_pkg::EV_COOL] = ~flag_next & OVERHEAT_FLAG;
    event_next      = event_reg;
    mask_next       = mask_reg;
    stagger_en_next = stagger_en_reg;
    rdata_next      = led_fault_pkg::WORD_ZERO;
    if (RST) begin
      event_next      = led_fault_pkg::EVENT_RST;
      mask_next       = led_fault_pkg::MASK_RST;
      stagger_en_next = led_fault_pkg::STAGGER_RST;
    end else if (CE) begin
      if (REG_WR && REG_ADDR == led_fault_pkg::ADDR_EVENT) begin
        event_next = event_reg & ~REG_WDATA[2:0];
      end
      if (REG_WR && REG_ADDR == led_fault_pkg::ADDR_MASK) begin
        mask_next = REG_WDATA[2:0];
      end
      if (REG_WR && REG_ADDR == led_fault_pkg::ADDR_CTRL) begin
        stagger_en_next = REG_WDATA[led_fault_pkg::CTRL_STAGGER];
      end
      event_next = event_next | event_set;
      if (REG_RD) begin
        case (REG_ADDR)
          led_fault_pkg::ADDR_EVENT: rdata_next[2:0] = event_reg;
          led_fault_pkg::ADDR_MASK:  rdata_next[2:0] = mask_reg;
          led_fault_pkg::ADDR_OPEN:  rdata_next = {15'h0000, status};
          led_fault_pkg::ADDR_CTRL:  rdata_next[0]   = stagger_en_reg;
          default:                   rdata_next = led_fault_pkg::WORD_ZERO;
        endcase
      end
    end
    irq_next = |(event_next & mask_next);
  end

  always_ff @(posedge REF_CLK) begin
    event_reg      <= event_next;
    mask_reg       <= mask_next;
    stagger_en_reg <= stagger_en_next;
    REG_RDATA      <= rdata_next;
    IRQ            <= irq_next;
  end

  // checks
  a_blank_off: assert property (@(posedge REF_CLK) disable iff (RST)
    CE && pins_s.blank |=> SINK_OUTPUT == 16'h0000)
    else $error("sink on while blank high");
  a_flag_off: assert property (@(posedge REF_CLK) disable iff (RST)
    CE && OVERHEAT_FLAG |=> SINK_OUTPUT == 16'h0000 ##0 !run_reg)
    else $error("sink on while overheated");
  a_hot_sets_flag: assert property (@(posedge REF_CLK) disable iff (RST)
    CE && pins_s.hot |=> OVERHEAT_FLAG)
    else $error("overheat flag not set");
  a_cool_clears: assert property (@(posedge REF_CLK) disable iff (RST)
    CE && pins_s.cool && !pins_s.hot |=> !OVERHEAT_FLAG)
    else $error("overheat flag not cleared");
  a_open_held: assert property (@(posedge REF_CLK) disable iff (RST)
    !sample |=> $stable(open_reg))
    else $error("open result changed outside sample");
  a_sample_edge: assert property (@(posedge REF_CLK) disable iff (RST)
    sample |-> gcount_reg == 6'h20 && counting_reg)
    else $error("sample not at 33rd shift clock");
  a_open_value: assert property (@(posedge REF_CLK) disable iff (RST)
    sample |=> open_reg == $past(open_cap))
    else $error("open result differs from comparator");
  a_restart_gate: assert property (@(posedge REF_CLK) disable iff (RST)
    $rose(run_reg) |-> $past(g_rise && resume_reg && !OVERHEAT_FLAG))
    else $error("restart without shift clock after blank");
  c_open_seen: cover property (@(posedge REF_CLK) sample && (|open_cap));
  c_flag_set: cover property (@(posedge REF_CLK) $rose(OVERHEAT_FLAG));
  c_restart: cover property (@(posedge REF_CLK) $rose(run_reg));

endmodule

// ---- hdl/led_gray_shift.sv ----
/*
  192-bit grayscale shift register with parallel status load into its
  top bits; serial output taken from the top flip-flop.
  Assumes shift and load are one-cycle enables, never both at once.
*/
`timescale 1ns/1ns
module led_gray_shift (
  // clock and control
  input  wire logic                          clk,
  input  wire logic                          ce,
  input  wire logic                          rst,
  input  wire logic                          shift_en,
  input  wire logic                          load_en,
  // data
  input  wire logic                          serial_in,
  input  wire led_fault_pkg::status_word_t   status,
  output logic                               serial_out
);

  localparam int LEN = led_fault_pkg::SHIFT_LEN;
  localparam int SB  = led_fault_pkg::STATUS_BITS;

  logic [LEN-1:0] sr_reg;
  logic [LEN-1:0] sr_next;

  always_comb begin
    sr_next = sr_reg;
    if (rst) begin
      sr_next = '0;
    end else if (ce && load_en) begin
      // only the top bits are overwritten, the rest keep their data
      sr_next[LEN-1 -: SB] = status;
    end else if (ce && shift_en) begin
      sr_next = {sr_reg[LEN-2:0], serial_in};
    end
  end

  always_ff @(posedge clk) begin
    sr_reg <= sr_next;
  end

  assign serial_out = sr_reg[LEN-1];

endmodule

// ---- hdl/led_pin_sync.sv ----
/*
  Two flip-flop synchroniser for a bundle of asynchronous levels.
  Assumes the inputs change slowly compared with the clock.
*/
`timescale 1ns/1ns
module led_pin_sync #(
  parameter int W = 1
) (
  // clock and control
  input  wire logic         clk,
  input  wire logic         ce,
  input  wire logic         rst,
  // levels
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_reg;
  logic [W-1:0] meta_next;
  logic [W-1:0] q_next;

  always_comb begin
    meta_next = meta_reg;
    q_next    = q;
    if (rst) begin
      meta_next = '0;
      q_next    = '0;
    end else if (ce) begin
      meta_next = d;
      q_next    = meta_reg;
    end
  end

  always_ff @(posedge clk) begin
    meta_reg <= meta_next;
    q        <= q_next;
  end

endmodule

// ---- verif/led_ctrl_model.sv ----
/*
  Behavioural display controller on the grayscale serial port.
  Assumes the caller runs its tasks from one process at a time.
*/
`timescale 1ns/1ns
module led_ctrl_model (
  // clock
  input  wire logic clk,
  // serial port to the device
  input  wire logic serial_out,
  output logic      shift_clock,
  output logic      serial_in,
  output logic      blank,
  output logic      latch_n
);
  // 84 ns shift clock period at a 4 ns system clock, 40 ns of it high
  localparam int HALF = 10;

  initial begin
    shift_clock = 1'b0;
    serial_in   = 1'b0;
    blank       = 1'b1;
    latch_n     = 1'b1;
  end

  task automatic wait_cycles(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic set_blank(input logic b);
    @(posedge clk);
    blank <= b;
    wait_cycles(HALF);
  endtask

  // shift clock stands low between pulses; data changes on the low half
  task automatic pulse();
    @(posedge clk);
    shift_clock <= 1'b1;
    wait_cycles(HALF);
    shift_clock <= 1'b0;
    serial_in   <= ~serial_in;
    wait_cycles(HALF);
  endtask

  task automatic pulses(input int n);
    repeat (n) pulse();
  endtask

  // strobe, then one rise loads and each later rise shifts one bit
  task automatic read_status(output logic [16:0] word);
    @(posedge clk);
    latch_n <= 1'b0;
    wait_cycles(HALF);
    latch_n <= 1'b1;
    for (int i = 16; i >= 0; i--) begin
      pulse();
      word[i] = serial_out;
    end
  endtask
endmodule

// ---- verif/led_fault_stagger_bench.sv ----
/*
  Self-checking bench of the LED fault detect and stagger block.
  Assumes the controller model drives the serial port pins.
*/
`timescale 1ns/1ns
module led_fault_stagger_bench;
  logic        REF_CLK;
  logic        RST;
  logic        CE;
  logic        GRAY_SHIFT_CLOCK;
  logic        GRAY_SERIAL_IN;
  logic        BLANK;
  logic        GRAY_LATCH_STROBE_N;
  logic        GRAY_SERIAL_OUT;
  logic        TEMP_HIGH;
  logic        TEMP_COOL;
  logic [15:0] OPEN_CMP;
  logic [15:0] CHANNEL_ON;
  logic [3:0]  REG_ADDR;
  logic [31:0] REG_WDATA;
  logic        REG_WR;
  logic        REG_RD;
  logic [31:0] REG_RDATA;
  logic [15:0] SINK_OUTPUT;
  logic        OVERHEAT_FLAG;
  logic        IRQ;
  int          bad_count;
  int          samples_checked;

  led_fault_stagger dut_u (
    .REF_CLK(REF_CLK), .RST(RST), .CE(CE),
    .GRAY_SHIFT_CLOCK(GRAY_SHIFT_CLOCK), .GRAY_SERIAL_IN(GRAY_SERIAL_IN),
    .BLANK(BLANK), .GRAY_LATCH_STROBE_N(GRAY_LATCH_STROBE_N),
    .GRAY_SERIAL_OUT(GRAY_SERIAL_OUT), .TEMP_HIGH(TEMP_HIGH),
    .TEMP_COOL(TEMP_COOL), .OPEN_CMP(OPEN_CMP), .CHANNEL_ON(CHANNEL_ON),
    .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR),
    .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .SINK_OUTPUT(SINK_OUTPUT),
    .OVERHEAT_FLAG(OVERHEAT_FLAG), .IRQ(IRQ)
  );

  led_ctrl_model ctrl_u (
    .clk(REF_CLK), .serial_out(GRAY_SERIAL_OUT),
    .shift_clock(GRAY_SHIFT_CLOCK), .serial_in(GRAY_SERIAL_IN),
    .blank(BLANK), .latch_n(GRAY_LATCH_STROBE_N)
  );

  initial begin
    REF_CLK = 1'b0;
    forever #2 REF_CLK = ~REF_CLK;
  end

  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
    @(posedge REF_CLK);
    REG_WR    <= 1'b1;
    REG_ADDR  <= a;
    REG_WDATA <= d;
    @(posedge REF_CLK);
    REG_WR    <= 1'b0;
  endtask

  task automatic reg_read(input logic [3:0] a, output logic [31:0] d);
    @(posedge REF_CLK);
    REG_RD   <= 1'b1;
    REG_ADDR <= a;
    @(posedge REF_CLK);
    REG_RD   <= 1'b0;
    #1;
    d = REG_RDATA;
  endtask

  function automatic logic [15:0] grp_mask(input int k);
    grp_mask = 16'h0000;
    for (int n = 0; n < 16; n++)
      if ((n % led_fault_pkg::GROUPS) <= k) grp_mask[n] = 1'b1;
  endfunction

  task automatic test_reset();
    logic [31:0] d;
    check("sinks", 32'h0000_0000, {16'h0000, SINK_OUTPUT});
    check("flag", 32'h0000_0000, {31'h0, OVERHEAT_FLAG});
    check("irq", 32'h0000_0000, {31'h0, IRQ});
    reg_read(led_fault_pkg::ADDR_CTRL, d);
    check("ctrl", 32'h0000_0001, d);
    reg_read(led_fault_pkg::ADDR_MASK, d);
    check("mask", 32'h0000_0000, d);
    reg_write(4'h2, 32'hFFFF_FFFF);
    reg_read(4'h2, d);
    check("unmapped", 32'h0000_0000, d);
    reg_write(led_fault_pkg::ADDR_OPEN, 32'hFFFF_FFFF);
    reg_read(led_fault_pkg::ADDR_OPEN, d);
    check("status read only", 32'h0000_0000, d);
    $display("test_reset done");
  endtask

  task automatic test_open();
    logic [31:0] d;
    logic [16:0] w;
    @(posedge REF_CLK);
    CHANNEL_ON <= 16'hFFFF;
    OPEN_CMP   <= 16'h00A5;
    ctrl_u.set_blank(1'b0);
    ctrl_u.pulses(32);
    reg_read(led_fault_pkg::ADDR_OPEN, d);
    check("open before sample", 32'h0000_0000, d);
    ctrl_u.pulse();
    reg_read(led_fault_pkg::ADDR_OPEN, d);
    check("open at sample", 32'h0000_00A5, d);
    reg_read(led_fault_pkg::ADDR_EVENT, d);
    check("open event", 32'h0000_0001, d);
    @(posedge REF_CLK);
    OPEN_CMP <= 16'h0F0F;
    ctrl_u.pulses(3);
    reg_read(led_fault_pkg::ADDR_OPEN, d);
    check("open held", 32'h0000_00A5, d);
    ctrl_u.read_status(w);
    check("serial status", 32'h0000_00A5, {15'h0, w});
    ctrl_u.set_blank(1'b1);
    check("blank off", 32'h0000_0000, {16'h0, SINK_OUTPUT});
    @(posedge REF_CLK);
    CHANNEL_ON <= 16'h0FF0;
    ctrl_u.set_blank(1'b0);
    ctrl_u.pulses(33);
    reg_read(led_fault_pkg::ADDR_OPEN, d);
    check("open second cycle", 32'h0000_0F00, d);
    $display("test_open done");
  endtask

  task automatic test_stagger();
    logic [15:0] e;
    // flush the delay stages so older demand cannot leak into group 1..3
    @(posedge REF_CLK);
    CHANNEL_ON <= 16'h0000;
    ctrl_u.pulses(3);
    check("stagger idle", 32'h0000_0000, {16'h0, SINK_OUTPUT});
    for (int on = 1; on >= 0; on--) begin
      @(posedge REF_CLK);
      CHANNEL_ON <= (on == 1) ? 16'hFFFF : 16'h0000;
      for (int k = 0; k < led_fault_pkg::GROUPS; k++) begin
        if (k == 0) ctrl_u.wait_cycles(8);
        else ctrl_u.pulse();
        e = (on == 1) ? grp_mask(k) : ~grp_mask(k);
        check("stagger", {16'h0, e}, {16'h0, SINK_OUTPUT});
      end
    end
    $display("test_stagger done");
  endtask

  task automatic test_thermal();
    logic [31:0] d;
    logic [16:0] w;
    @(posedge REF_CLK);
    CHANNEL_ON <= 16'hFFFF;
    ctrl_u.pulses(4);
    reg_write(led_fault_pkg::ADDR_EVENT, 32'h0000_0007);
    reg_write(led_fault_pkg::ADDR_MASK, 32'h0000_0002);
    @(posedge REF_CLK);
    TEMP_COOL <= 1'b0;
    TEMP_HIGH <= 1'b1;
    ctrl_u.wait_cycles(8);
    check("hot sinks", 32'h0000_0000, {16'h0, SINK_OUTPUT});
    check("hot flag", 32'h0000_0001, {31'h0, OVERHEAT_FLAG});
    check("hot irq", 32'h0000_0001, {31'h0, IRQ});
    ctrl_u.read_status(w);
    check("serial flag", 32'h0000_0001, {31'h0, w[16]});
    reg_write(led_fault_pkg::ADDR_EVENT, 32'h0000_0002);
    ctrl_u.wait_cycles(2);
    check("irq cleared", 32'h0000_0000, {31'h0, IRQ});
    @(posedge REF_CLK);
    TEMP_HIGH <= 1'b0;
    TEMP_COOL <= 1'b1;
    ctrl_u.wait_cycles(8);
    check("cool flag", 32'h0000_0000, {31'h0, OVERHEAT_FLAG});
    check("cool event masked", 32'h0000_0000, {31'h0, IRQ});
    ctrl_u.pulses(3);
    check("still off", 32'h0000_0000, {16'h0, SINK_OUTPUT});
    ctrl_u.set_blank(1'b1);
    ctrl_u.set_blank(1'b0);
    check("off before rise", 32'h0000_0000, {16'h0, SINK_OUTPUT});
    ctrl_u.pulse();
    check("restart", 32'h0000_FFFF, {16'h0, SINK_OUTPUT});
    $display("test_thermal done");
  endtask

  // clock enable low must freeze synchronisers, flag and register port
  task automatic test_freeze();
    logic [31:0] d;
    @(posedge REF_CLK);
    CE        <= 1'b0;
    TEMP_COOL <= 1'b0;
    TEMP_HIGH <= 1'b1;
    ctrl_u.wait_cycles(8);
    check("frozen flag", 32'h0000_0000, {31'h0, OVERHEAT_FLAG});
    reg_read(led_fault_pkg::ADDR_CTRL, d);
    check("frozen read", 32'h0000_0000, d);
    @(posedge REF_CLK);
    TEMP_HIGH <= 1'b0;
    TEMP_COOL <= 1'b1;
    ctrl_u.wait_cycles(4);
    CE <= 1'b1;
    ctrl_u.wait_cycles(8);
    check("thawed flag", 32'h0000_0000, {31'h0, OVERHEAT_FLAG});
    check("thawed sinks", 32'h0000_FFFF, {16'h0, SINK_OUTPUT});
    // a second reset in mid-run must force every sink off
    @(posedge REF_CLK);
    RST <= 1'b1;
    ctrl_u.wait_cycles(3);
    RST <= 1'b0;
    ctrl_u.wait_cycles(2);
    check("mid reset sinks", 32'h0000_0000, {16'h0, SINK_OUTPUT});
    reg_read(led_fault_pkg::ADDR_CTRL, d);
    check("mid reset ctrl", 32'h0000_0001, d);
    $display("test_freeze done");
  endtask

  task automatic finish_test();
    $display("checked %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // tests need about 11 us; allow a wide margin
  initial begin
    #200000;
    bad_count++;
    $display("Error watchdog expected done seen hang");
    finish_test();
  end

  initial begin
    bad_count       = 0;
    samples_checked = 0;
    RST        = 1'b1;
    CE         = 1'b1;
    TEMP_HIGH  = 1'b0;
    TEMP_COOL  = 1'b1;
    OPEN_CMP   = 16'h0000;
    CHANNEL_ON = 16'h0000;
    REG_ADDR   = 4'h0;
    REG_WDATA  = 32'h0000_0000;
    REG_WR     = 1'b0;
    REG_RD     = 1'b0;
    repeat (3) @(posedge REF_CLK);
    RST <= 1'b0;
    ctrl_u.wait_cycles(4);
    test_reset();
    test_open();
    test_stagger();
    test_thermal();
    test_freeze();
    finish_test();
  end
endmodule
